/* File: hw/coast_trip_params.svh */
/*
  Offsets, field positions, reset values and timing counts of the
  coast-stop / external-trip / start-guard controller.
  Assumes inclusion by bare name from the package and the modules.
*/
`ifndef COAST_TRIP_PARAMS_SVH
`define COAST_TRIP_PARAMS_SVH

// Register byte offsets
`define ADDR_FUNC 8'h00
`define ADDR_CFG 8'h04
`define ADDR_DELAY 8'h08
`define ADDR_STATUS 8'h0C
`define ADDR_INT_STAT 8'h10
`define ADDR_INT_MASK 8'h14

// Reset values
`define FUNC_RESET 20'h0_0DCB
`define POL_RESET 5'h00
`define DELAY_RESET 16'h0000
`define MASK_RESET 3'h0

// Terminal function codes
`define FN_COAST 4'hB
`define FN_EXT 4'hC
`define FN_GUARD 4'hD

// Error codes shown to the operator
`define ERR_NONE 8'h00
`define ERR_EXT 8'h0C
`define ERR_GUARD 8'h0D

// Field positions in the config word
`define CFG_RESUME_BIT 8
`define CFG_KEYPAD_BIT 16

// Interrupt bit positions
`define IRQ_EXT 0
`define IRQ_GUARD 1
`define IRQ_COAST 2

// Timing
`define TERM_W 7
`define POWERUP_CYCLES 3'h3
`define CLK_HZ 32'h02FA_F080
`define MS_PER_S 32'h0000_03E8

`endif

/* File: hw/coast_trip_pkg.sv */
/*
  Types shared by the controller and its terminal conditioner.
  Assumes the params header is on the include path.
*/
`default_nettype none
`include "coast_trip_params.svh"

package coast_trip_pkg;
  // Drive control states
  typedef enum logic [2:0] {
    ST_POWERUP, ST_STOPPED, ST_RUNNING, ST_COASTING,
    ST_WAITING, ST_TRIPPED, ST_CLEARING
  } drive_state_t;

  // Conditioned terminal levels and rising edges
  typedef struct packed {
    logic [`TERM_W-1:0] level;
    logic [`TERM_W-1:0] rise;
  } term_t;

  // Conditioner state
  typedef struct packed {
    logic [`TERM_W-1:0] s1;
    logic [`TERM_W-1:0] s2;
    logic [`TERM_W-1:0] lvl;
    logic [`TERM_W-1:0] prv;
  } cond_t;

  // Controller state
  typedef struct packed {
    drive_state_t st;
    logic [2:0] pu_cnt;
    logic [15:0] tick_cnt;
    logic [15:0] ms_cnt;
    logic need_edge;
    logic [7:0] err;
    logic [7:0] trips;
    logic [19:0] func;
    logic [4:0] pol;
    logic resume_sel;
    logic [15:0] delay;
    logic [2:0] irq_stat;
    logic [2:0] irq_mask;
    logic [31:0] rdata;
    logic resume_speed;
    logic ramp_stop;
  } core_t;
endpackage : coast_trip_pkg

`default_nettype wire

/* File: hw/term_cond.sv */
/*
  Terminal conditioner: two-flop synchroniser, polarity, edge detect.
  Assumes raw inputs are asynchronous pins and polarity is static.
*/
`default_nettype none
`include "coast_trip_params.svh"

module term_cond (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Pins and polarity
  input wire logic [`TERM_W-1:0] raw,
  input wire logic [`TERM_W-1:0] pol,
  // Conditioned view
  output coast_trip_pkg::term_t term
);
  import coast_trip_pkg::*;

  cond_t s_reg; // All conditioner state
  cond_t s_next; // Its next value

  // Sync chain, then polarity, then history for edges
  always_comb begin
    s_next = s_reg;
    s_next.s1 = raw;
    s_next.s2 = s_reg.s1;
    s_next.lvl = s_reg.s2 ^ pol;
    s_next.prv = s_reg.lvl;
  end

  // State register
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  // A polarity change flips the level and can look like an edge
  assign term.level = s_reg.lvl;
  assign term.rise = s_reg.lvl & ~s_reg.prv;
endmodule : term_cond

`default_nettype wire

/* File: hw/drive_guard_ctrl.sv */
/*
  Coast-stop, external trip and start-guard control of a motor drive,
  with a small register port and one level interrupt.
  Assumes terminal pins are asynchronous and the bus is on clock.
*/
// The address map and the plain strobed port were chosen for this implementation.
`default_nettype none
`include "coast_trip_params.svh"

// What this block does
// - Coast input turns power output off
// - Coast release resumes only with run
// - Setting picks restart from zero or speed
// - Restart delay waits; zero means none
// - Per-terminal polarity allows active low
// - Coast deasserted: stop decelerates normally
// - Fault rising edge latches trip, code
// - Fault release does not clear trip
// - Only reset clears fault trip, then stopped
// - Trip coasts motor, alarm at once
// - Reset clears alarm; release restarts
// - Fault falling edge no event; history kept
// - Guard needs fresh run after fault trip
// - Unguarded: run at power-up starts
// - Guarded: power-up start is blocked
// - Guard trip shows its code, alarm
// - Reset of guard trip restarts immediately
module drive_guard_ctrl #(
  parameter int unsigned TICK_CYCLES = `CLK_HZ / `MS_PER_S
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Terminal pins
  input wire logic [4:0] terminal_in,
  input wire logic forward_run_input,
  input wire logic fault_clear_input,
  // Register port
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  // Drive outputs
  output logic power_output_on,
  output logic resume_from_sensed,
  output logic ramp_stop,
  output logic alarm_out,
  output logic [7:0] error_code,
  // Interrupt
  output logic irq
);
  import coast_trip_pkg::*;

  core_t s_reg; // All controller state
  core_t s_next; // Its next value
  term_t term; // Conditioned terminals
  logic [`TERM_W-1:0] pol_all; // Polarity incl. fixed pins
  logic [4:0] is_coast; // Terminal carries coast
  logic [4:0] is_ext; // Terminal carries fault
  logic [4:0] is_guard; // Terminal carries guard
  logic coast; // Coast asserted
  logic ext_rise; // Fault off-to-on
  logic guard; // Guard asserted
  logic run; // Run command level
  logic run_rise; // Fresh run edge
  logic clear_lvl; // Reset terminal level
  logic keypad; // Keypad reset pulse
  logic clear_req; // Any reset request
  logic tick; // One millisecond passed
  logic [2:0] ev; // Interrupt events

  // Fixed pins are always active high
  assign pol_all = {2'b00, s_reg.pol};

  // Synchronise and condition every pin
  term_cond u_cond (
    .clock(clock),
    .rst_n(rst_n),
    .raw({fault_clear_input, forward_run_input, terminal_in}),
    .pol(pol_all),
    .term(term)
  );

  // Function decode per terminal
  for (genvar i = 0; i < 5; i++) begin : g_fn
    assign is_coast[i] = s_reg.func[4*i +: 4] == `FN_COAST;
    assign is_ext[i] = s_reg.func[4*i +: 4] == `FN_EXT;
    assign is_guard[i] = s_reg.func[4*i +: 4] == `FN_GUARD;
  end

  assign coast = |(is_coast & term.level[4:0]);
  assign ext_rise = |(is_ext & term.rise[4:0]);
  assign guard = |(is_guard & term.level[4:0]);
  assign run = term.level[5];
  assign run_rise = term.rise[5];
  assign clear_lvl = term.level[6];
  // Keypad reset is a one-shot write
  assign keypad = wr && addr == `ADDR_CFG && wdata[`CFG_KEYPAD_BIT];
  assign clear_req = clear_lvl | keypad;
  assign tick = s_reg.tick_cnt == 16'(TICK_CYCLES - 1);

  // Control sequence, timers and register file
  always_comb begin
    s_next = s_reg;
    ev = 3'h0;
    s_next.ramp_stop = 1'b0;
    s_next.rdata = 32'h0000_0000;
    case (s_reg.st)
      // Let the sync chain fill before judging run
      ST_POWERUP: begin
        if (s_reg.pu_cnt != `POWERUP_CYCLES) begin
          s_next.pu_cnt = s_reg.pu_cnt + 3'h1;
        end else if (run && guard) begin
          s_next.st = ST_TRIPPED;
          s_next.err = `ERR_GUARD;
          ev[`IRQ_GUARD] = 1'b1;
        end else begin
          s_next.st = ST_STOPPED;
        end
      end
      // Idle; starts as soon as run allows
      ST_STOPPED: begin
        if (run_rise || clear_req) begin
          s_next.need_edge = 1'b0;
        end
        if (run && (!s_reg.need_edge || run_rise)) begin
          s_next.st = ST_RUNNING;
          s_next.resume_speed = 1'b0;
        end
      end
      // Power on the motor
      ST_RUNNING: begin
        if (coast) begin
          s_next.st = ST_COASTING;
          ev[`IRQ_COAST] = 1'b1;
        end else if (!run) begin
          s_next.st = ST_STOPPED;
          s_next.ramp_stop = 1'b1;
        end
      end
      // Output off until coast releases
      ST_COASTING: begin
        s_next.tick_cnt = 16'h0000;
        s_next.ms_cnt = 16'h0000;
        if (!coast) begin
          if (!run) begin
            s_next.st = ST_STOPPED;
          end else if (s_reg.delay == 16'h0000) begin
            s_next.st = ST_RUNNING;
            s_next.resume_speed = s_reg.resume_sel;
          end else begin
            s_next.st = ST_WAITING;
          end
        end
      end
      // Restart delay in milliseconds
      ST_WAITING: begin
        if (coast) begin
          s_next.st = ST_COASTING;
        end else if (!run) begin
          s_next.st = ST_STOPPED;
        end else if (s_reg.ms_cnt >= s_reg.delay) begin
          s_next.st = ST_RUNNING;
          s_next.resume_speed = s_reg.resume_sel;
        end else begin
          s_next.tick_cnt = tick ? 16'h0000 : s_reg.tick_cnt + 16'h0001;
          if (tick) begin
            s_next.ms_cnt = s_reg.ms_cnt + 16'h0001;
          end
        end
      end
      // Latched; fault level is ignored here
      ST_TRIPPED: begin
        if (clear_req) begin
          s_next.st = ST_CLEARING;
          // Guarded drive waits for a new edge after a fault trip
          s_next.need_edge = guard && s_reg.err == `ERR_EXT;
          s_next.err = `ERR_NONE;
          s_next.trips = 8'h00;
        end else if (s_reg.err == `ERR_GUARD && !run) begin
          // Dropping run also cancels a guard trip
          s_next.st = ST_STOPPED;
          s_next.err = `ERR_NONE;
        end
      end
      // Wait for the reset terminal to drop
      ST_CLEARING: begin
        if (!clear_lvl) begin
          // Guard trip reset restarts at once
          s_next.st = ST_STOPPED;
        end
      end
      default: begin
        s_next.st = ST_STOPPED;
      end
    endcase
    // Fault edge overrides every state
    if (ext_rise) begin
      s_next.st = ST_TRIPPED;
      s_next.err = `ERR_EXT;
      s_next.trips = s_reg.trips + 8'h01;
      ev[`IRQ_EXT] = 1'b1;
    end
    // Register writes
    if (wr) begin
      case (addr)
        `ADDR_FUNC: s_next.func = wdata[19:0];
        `ADDR_CFG: begin
          s_next.pol = wdata[4:0];
          s_next.resume_sel = wdata[`CFG_RESUME_BIT];
        end
        `ADDR_DELAY: s_next.delay = wdata[15:0];
        `ADDR_INT_STAT: s_next.irq_stat = s_reg.irq_stat & ~wdata[2:0];
        `ADDR_INT_MASK: s_next.irq_mask = wdata[2:0];
        default: begin
        end
      endcase
    end
    // New events win over a same-cycle clear
    s_next.irq_stat = s_next.irq_stat | ev;
    // Reads answer one cycle later; unmapped reads zero
    if (rd) begin
      case (addr)
        `ADDR_FUNC: s_next.rdata = {12'h000, s_reg.func};
        `ADDR_CFG: s_next.rdata = {23'h00_0000, s_reg.resume_sel, 3'h0, s_reg.pol};
        `ADDR_DELAY: s_next.rdata = {16'h0000, s_reg.delay};
        `ADDR_STATUS: begin
          s_next.rdata = {s_reg.trips, 6'h00, s_reg.st == ST_RUNNING,
                          s_reg.err != `ERR_NONE, s_reg.err, 5'h00, s_reg.st};
        end
        `ADDR_INT_STAT: s_next.rdata = {29'h0000_0000, s_reg.irq_stat};
        `ADDR_INT_MASK: s_next.rdata = {29'h0000_0000, s_reg.irq_mask};
        default: s_next.rdata = 32'h0000_0000;
      endcase
    end
  end

  // State register
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      s_reg <= '0;
      s_reg.st <= ST_POWERUP;
      s_reg.func <= `FUNC_RESET;
      s_reg.pol <= `POL_RESET;
      s_reg.delay <= `DELAY_RESET;
      s_reg.irq_mask <= `MASK_RESET;
      s_reg.err <= `ERR_NONE;
    end else begin
      s_reg <= s_next;
    end
  end

  // Outputs straight from state
  assign rdata = s_reg.rdata;
  // Trip forces coast, alarm at once
  assign power_output_on = s_reg.st == ST_RUNNING;
  assign resume_from_sensed = s_reg.resume_speed;
  assign ramp_stop = s_reg.ramp_stop;
  assign alarm_out = s_reg.err != `ERR_NONE;
  assign error_code = s_reg.err;
  assign irq = |(s_reg.irq_stat & s_reg.irq_mask);

  // Checks on the control sequence
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);

  sequence coast_release_s;
    s_reg.st == ST_COASTING && !coast && run && !ext_rise;
  endsequence

  sequence ext_latched_s;
    s_reg.st == ST_TRIPPED && error_code == `ERR_EXT && alarm_out;
  endsequence

  coast_off_a: assert property (
    s_reg.st == ST_RUNNING && coast && !ext_rise |=> !power_output_on [*2])
    else $error("coast did not cut output");
  resume_norun_a: assert property (
    s_reg.st == ST_COASTING && !coast && !run && !ext_rise |=> s_reg.st == ST_STOPPED)
    else $error("resumed without run");
  resume_speed_a: assert property (
    coast_release_s and s_reg.delay == 16'h0000 |=>
      power_output_on && resume_from_sensed == $past(s_reg.resume_sel))
    else $error("wrong resume speed");
  wait_delay_a: assert property (
    coast_release_s and s_reg.delay != 16'h0000 |=> !power_output_on [*3])
    else $error("restart delay skipped");
  stop_decel_a: assert property (
    s_reg.st == ST_RUNNING && !run && !coast && !ext_rise |=>
      ramp_stop && s_reg.st == ST_STOPPED)
    else $error("stop did not decelerate");
  ext_trip_a: assert property (
    ext_rise |=> ext_latched_s and !power_output_on)
    else $error("fault edge did not trip");
  trip_hold_a: assert property (
    ext_latched_s and !clear_req |=> ext_latched_s)
    else $error("trip lost without reset");
  trip_clear_a: assert property (
    ext_latched_s and clear_req && !ext_rise |=>
      !alarm_out && s_reg.st == ST_CLEARING)
    else $error("reset did not clear alarm");
  guard_boot_a: assert property (
    s_reg.st == ST_POWERUP && s_reg.pu_cnt == `POWERUP_CYCLES && run && guard
      && !ext_rise |=> error_code == `ERR_GUARD && alarm_out && !power_output_on)
    else $error("guard did not block start");
  autostart_a: assert property (
    s_reg.st == ST_STOPPED && run && !s_reg.need_edge && !ext_rise |=> power_output_on)
    else $error("run did not start drive");
  fall_quiet_a: assert property (
    $fell(|(is_ext & term.level[4:0])) && !ext_rise && s_reg.st != ST_TRIPPED
      |=> error_code != `ERR_EXT)
    else $error("fault release tripped");
endmodule : drive_guard_ctrl

`default_nettype wire

/* File: tb/switch_panel.sv */
/*
  Operator switches and relay contacts on the drive's input terminals.
  Assumes the bench changes contact states right after a clock edge.
*/
`default_nettype none
module switch_panel (
  // Contact states, 1 = closed or asserted
  input wire logic coast_on,
  input wire logic fault_on,
  input wire logic guard_on,
  input wire logic run_on,
  input wire logic clear_on,
  // Coast contact wiring, 1 = normally closed
  input wire logic coast_nc,
  // Terminal pins
  output logic [4:0] terminal_in,
  output logic forward_run_input,
  output logic fault_clear_input
);
  timeunit 1ns;
  timeprecision 1ps;
  assign terminal_in[0] = coast_nc ? ~coast_on : coast_on;
  // Spare terminals open, pulled low by the input stage
  assign terminal_in[4:1] = {2'b00, guard_on, fault_on};
  assign forward_run_input = run_on;
  assign fault_clear_input = clear_on;
endmodule : switch_panel
`default_nettype wire

/* File: tb/coast_stop_and_external_trip_tb.sv */
/*
  Self-checking bench for the coast / trip / start-guard controller.
  Assumes the design and its params header are compiled before it.
*/
`default_nettype none
`include "coast_trip_params.svh"
module coast_stop_and_external_trip_tb;
  timeunit 1ns;
  timeprecision 1ps;
  // Short ms tick keeps delay runs brief
  localparam int TICK = 4;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [31:0] rdata;
  logic pwr, sensed, ramp, alarm, irq;
  logic [7:0] err;
  // Contact states handed to the switch model
  logic coast = 1'b0, fault = 1'b0, guard = 1'b0, run = 1'b1, clr = 1'b0, nc = 1'b0;
  logic [4:0] term;
  logic fwd, rsw, seen;
  int error_cnt = 0;
  int check_count = 0;
  int n;
  // 50 MHz clock
  always #10 clock = ~clock;
  switch_panel panel_u (.coast_on(coast), .fault_on(fault), .guard_on(guard), .run_on(run),
    .clear_on(clr), .coast_nc(nc), .terminal_in(term), .forward_run_input(fwd),
    .fault_clear_input(rsw));
  drive_guard_ctrl #(.TICK_CYCLES(TICK)) dut_u (.clock(clock), .rst_n(rst_n),
    .terminal_in(term), .forward_run_input(fwd), .fault_clear_input(rsw), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .power_output_on(pwr),
    .resume_from_sensed(sensed), .ramp_stop(ramp), .alarm_out(alarm), .error_code(err),
    .irq(irq));
  // Verdict and end of run
  task automatic give_verdict();
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : give_verdict
  // One comparison
  task automatic check(input string name, input logic [31:0] seen_v, input logic [31:0] exp);
    check_count++;
    if (seen_v !== exp) begin
      error_cnt++;
      $display("unexpected %s expected %h seen %h", name, exp, seen_v);
    end
  endtask : check
  // One-cycle write strobe
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
  endtask : wr_reg
  // Read strobe, data compared in the following cycle
  task automatic rd_chk(input string name, input logic [7:0] a, input logic [31:0] exp);
    @(posedge clock);
    addr <= a;
    rd <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    #1;
    check(name, rdata, exp);
  endtask : rd_chk
  // Bounded wait on the power output, cycles counted
  task automatic wait_pwr(input logic v, output int cnt);
    for (cnt = 1; cnt < 100; cnt++) begin
      @(posedge clock);
      #1;
      if (pwr === v) return;
    end
    error_cnt++;
    $display("unexpected timeout power output %b", v);
    give_verdict();
  endtask : wait_pwr
  // Main sequence
  initial begin
    repeat (5) @(posedge clock);
    rst_n <= 1'b1;
    rd_chk("func", `ADDR_FUNC, {12'h000, `FUNC_RESET});
    rd_chk("unmapped", 8'h20, 32'h0000_0000);
    wait_pwr(1'b1, n);
    check("start speed", sensed, 1'b0);
    rd_chk("status run", `ADDR_STATUS, 32'h0002_0002);
    wr_reg(`ADDR_INT_MASK, 32'h0000_0007);
    wr_reg(`ADDR_CFG, 32'h0000_0100);
    @(posedge clock) coast <= 1'b1;
    wait_pwr(1'b0, n);
    check("coast latency", n <= 6, 1'b1);
    check("coast irq", irq, 1'b1);
    rd_chk("coast stat", `ADDR_INT_STAT, 32'h0000_0004);
    @(posedge clock) coast <= 1'b0;
    wait_pwr(1'b1, n);
    check("zero delay", n <= 8, 1'b1);
    check("sensed resume", sensed, 1'b1);
    wr_reg(`ADDR_INT_STAT, 32'h0000_0004);
    @(posedge clock);
    #1;
    check("irq clear", irq, 1'b0);
    wr_reg(`ADDR_DELAY, 32'h0000_0003);
    @(posedge clock) coast <= 1'b1;
    wait_pwr(1'b0, n);
    @(posedge clock) coast <= 1'b0;
    wait_pwr(1'b1, n);
    check("delay wait", n >= 3 * TICK && n <= 3 * TICK + 10, 1'b1);
    wr_reg(`ADDR_DELAY, 32'h0000_0000);
    @(posedge clock) coast <= 1'b1;
    wait_pwr(1'b0, n);
    @(posedge clock) run <= 1'b0;
    repeat (4) @(posedge clock);
    coast <= 1'b0;
    repeat (20) @(posedge clock);
    #1;
    check("no run", pwr, 1'b0);
    @(posedge clock) run <= 1'b1;
    wait_pwr(1'b1, n);
    check("zero hz start", sensed, 1'b0);
    // Active-low coast contact
    // Rewire first: the open contact coasts until polarity flips, so no short glitch
    @(posedge clock) nc <= 1'b1;
    wait_pwr(1'b0, n);
    wr_reg(`ADDR_CFG, 32'h0000_0101);
    wait_pwr(1'b1, n);
    repeat (6) @(posedge clock);
    coast <= 1'b1;
    wait_pwr(1'b0, n);
    rd_chk("status coast", `ADDR_STATUS, 32'h0000_0003);
    @(posedge clock) coast <= 1'b0;
    wait_pwr(1'b1, n);
    wr_reg(`ADDR_INT_STAT, 32'h0000_0007);
    @(posedge clock) fault <= 1'b1;
    wait_pwr(1'b0, n);
    check("trip latency", n <= 5, 1'b1);
    check("trip code", err, `ERR_EXT);
    check("trip alarm", alarm, 1'b1);
    check("trip irq", irq, 1'b1);
    @(posedge clock) fault <= 1'b0;
    repeat (10) @(posedge clock);
    rd_chk("status trip", `ADDR_STATUS, 32'h0101_0C05);
    @(posedge clock) clr <= 1'b1;
    repeat (6) @(posedge clock);
    #1;
    check("clear code", err, `ERR_NONE);
    check("clear alarm", alarm, 1'b0);
    @(posedge clock) clr <= 1'b0;
    wait_pwr(1'b1, n);
    rd_chk("history", `ADDR_STATUS, 32'h0002_0002);
    wr_reg(`ADDR_INT_STAT, 32'h0000_0007);
    @(posedge clock) guard <= 1'b1;
    fault <= 1'b1;
    wait_pwr(1'b0, n);
    @(posedge clock) fault <= 1'b0;
    clr <= 1'b1;
    repeat (4) @(posedge clock);
    clr <= 1'b0;
    repeat (20) @(posedge clock);
    rd_chk("guarded stop", `ADDR_STATUS, 32'h0000_0001);
    @(posedge clock) run <= 1'b0;
    repeat (4) @(posedge clock);
    run <= 1'b1;
    wait_pwr(1'b1, n);
    @(posedge clock) run <= 1'b0;
    seen = 1'b0;
    repeat (10) begin
      @(posedge clock);
      #1;
      if (ramp === 1'b1) seen = 1'b1;
    end
    check("ramp stop", seen, 1'b1);
    @(posedge clock);
    nc <= 1'b0;
    run <= 1'b1;
    rst_n <= 1'b0;
    repeat (3) @(posedge clock);
    rst_n <= 1'b1;
    repeat (15) @(posedge clock);
    #1;
    check("blocked start", pwr, 1'b0);
    check("guard code", err, `ERR_GUARD);
    check("guard alarm", alarm, 1'b1);
    check("masked irq", irq, 1'b0);
    rd_chk("guard stat", `ADDR_INT_STAT, 32'h0000_0002);
    wr_reg(`ADDR_CFG, 32'h0001_0100);
    wait_pwr(1'b1, n);
    check("guard restart", n <= 10, 1'b1);
    give_verdict();
  end
endmodule : coast_stop_and_external_trip_tb
`default_nettype wire
